// >>> pmc_power_mgmt_control.sv
// pmc_power_mgmt_control: power management control register bank
// assumes apb master on REF_CLK; event inputs are pins, synchronised here
`timescale 1ns/100ps
module pmc_power_mgmt_control
	import pmc_pkg::*;
#(
	parameter int WDOG_CYCLES = PMC_WDOG_CYC
)
(
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic RESUME_DONE,
	input wire logic RESUME_REMOTE,
	input wire logic CONFIG_DONE,
	input wire logic PHY_CLK_OK,
	input wire logic DECONFIG,
	input wire logic LITE_RESET,
	input wire logic [PMC_N_FLAG-1:0] FLAG_SET,
	input wire logic [1:0] CAUSE_SET,
	output logic [1:0] SUSPEND_VARIANT,
	output logic READY,
	output logic IRQ
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [5:0] s1;
		logic [5:0] s2;
		logic [PMC_N_FLAG-1:0] fs1;
		logic [PMC_N_FLAG-1:0] fs2;
		logic [1:0] cs1;
		logic [1:0] cs2;
		logic done_d;
		logic deconf_d;
		pmc_state_t st;
		logic [31:0] wdog;
		logic rcs;
		logic rce;
		logic rdy;
		logic [1:0] sus;
		logic [1:0] cause;
		logic [PMC_N_FLAG-1:0] flags;
		logic [PMC_N_KEEP-1:0] keep_en;
		logic [PMC_N_CLR-1:0] clr_en;
		logic [PMC_N_IRQ-1:0] ists;
		logic [PMC_N_IRQ-1:0] ien;
		logic irq;
		logic [31:0] rdata;
		logic ready;
		logic err;
	} pmc_reg_t;

	pmc_reg_t r_ff;
	pmc_reg_t nxt_r;
	logic [5:0] pins;
	logic done_p;
	logic deconf_p;
	logic remote;
	logic phy_ok;
	logic lite;
	logic wr;
	logic rd;
	logic hit;
	logic [31:0] ctl_rd;
	logic [31:0] wake_rd;
	logic [PMC_N_IRQ-1:0] iev;

	assign pins = {LITE_RESET, DECONFIG, PHY_CLK_OK, CONFIG_DONE,
		RESUME_REMOTE, RESUME_DONE};
	assign done_p = r_ff.s2[0] & ~r_ff.done_d;
	assign remote = r_ff.s2[1];
	assign phy_ok = r_ff.s2[3];
	assign deconf_p = r_ff.s2[4] & ~r_ff.deconf_d;
	assign lite = r_ff.s2[5];
	assign wr = PSEL & PENABLE & PWRITE & r_ff.ready;
	assign rd = PSEL & ~PENABLE & ~PWRITE;
	assign hit = (PADDR == PMC_OFS_CTL) | (PADDR == PMC_OFS_WAKE) |
		(PADDR == PMC_OFS_IRQ_STS) | (PADDR == PMC_OFS_IRQ_EN) |
		(PADDR == PMC_OFS_IRQ_CLR);

	always_comb
	begin
		ctl_rd = '0;
		ctl_rd[PMC_BIT_RCS] = r_ff.rcs;
		ctl_rd[PMC_BIT_RCE] = r_ff.rce;
		ctl_rd[PMC_BIT_RDY] = r_ff.rdy;
		ctl_rd[PMC_BIT_SUS_LO +: 2] = r_ff.sus;
		ctl_rd[PMC_BIT_CAUSE_LO +: 2] = r_ff.cause;
		wake_rd = '0;
		wake_rd[PMC_N_FLAG-1:0] = r_ff.flags;
		wake_rd[PMC_BIT_KEEP +: PMC_N_KEEP] = r_ff.keep_en;
		wake_rd[PMC_BIT_CLR +: PMC_N_CLR] = r_ff.clr_en;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.s1 = pins;
		nxt_r.s2 = r_ff.s1;
		nxt_r.fs1 = FLAG_SET;
		nxt_r.fs2 = r_ff.fs1;
		nxt_r.cs1 = CAUSE_SET;
		nxt_r.cs2 = r_ff.cs1;
		nxt_r.done_d = r_ff.s2[0];
		nxt_r.deconf_d = r_ff.s2[4];
		iev = '0;
		// register writes
		if (wr && PADDR == PMC_OFS_CTL)
		begin
			nxt_r.rcs = PWDATA[PMC_BIT_RCS];
			nxt_r.rce = PWDATA[PMC_BIT_RCE];
			nxt_r.sus = PWDATA[PMC_BIT_SUS_LO +: 2];
			nxt_r.cause = r_ff.cause & ~PWDATA[PMC_BIT_CAUSE_LO +: 2];
		end
		if (wr && PADDR == PMC_OFS_WAKE)
		begin
			nxt_r.flags = r_ff.flags & ~PWDATA[PMC_N_FLAG-1:0];
			nxt_r.keep_en = PWDATA[PMC_BIT_KEEP +: PMC_N_KEEP];
			nxt_r.clr_en = PWDATA[PMC_BIT_CLR +: PMC_N_CLR];
		end
		if (wr && PADDR == PMC_OFS_IRQ_EN)
			nxt_r.ien = PWDATA[PMC_N_IRQ-1:0];
		if (wr && PADDR == PMC_OFS_IRQ_CLR)
			nxt_r.ists = r_ff.ists & ~PWDATA[PMC_N_IRQ-1:0];
		// resume completion
		if (done_p)
		begin
			iev[PMC_IRQ_RESUME] = 1'b1;
			if (r_ff.rcs)
			begin
				nxt_r.flags = '0;
				nxt_r.cause[PMC_BIT_CAUSE_HI] = 1'b0;
			end
			if (r_ff.rce && remote)
				nxt_r.clr_en = '0;
		end
		// hardware sets win over clears
		nxt_r.flags = nxt_r.flags | r_ff.fs2;
		nxt_r.cause = nxt_r.cause | r_ff.cs2;
		// readiness sequencing
		unique case (r_ff.st)
			PMC_ST_RESET:
			begin
				nxt_r.wdog = '0;
				nxt_r.st = PMC_ST_CONFIG;
			end
			PMC_ST_CONFIG:
			begin
				nxt_r.wdog = r_ff.wdog + 32'h1;
				if (r_ff.s2[2] && (phy_ok || r_ff.wdog >= WDOG_CYCLES))
					nxt_r.st = PMC_ST_NORMAL;
			end
			PMC_ST_NORMAL:
				nxt_r.st = PMC_ST_NORMAL;
		endcase
		if (lite)
			nxt_r.st = PMC_ST_RESET;
		nxt_r.rdy = (nxt_r.st == PMC_ST_NORMAL);
		if (nxt_r.rdy && !r_ff.rdy)
			iev[PMC_IRQ_READY] = 1'b1;
		if (deconf_p)
		begin
			nxt_r.sus = PMC_SUS_RST;
			nxt_r.st = PMC_ST_RESET;
			nxt_r.rdy = 1'b0;
			iev[PMC_IRQ_DECONF] = 1'b1;
		end
		nxt_r.ists = nxt_r.ists | iev;
		nxt_r.irq = |(nxt_r.ists & nxt_r.ien);
		// apb answer: setup decode, ready in access
		nxt_r.ready = PSEL & ~PENABLE;
		nxt_r.err = PSEL & ~PENABLE & ~hit;
		if (rd)
		begin
			unique case (PADDR)
				PMC_OFS_CTL: nxt_r.rdata = ctl_rd;
				PMC_OFS_WAKE: nxt_r.rdata = wake_rd;
				PMC_OFS_IRQ_STS: nxt_r.rdata = 32'(r_ff.ists);
				PMC_OFS_IRQ_EN: nxt_r.rdata = 32'(r_ff.ien);
				default: nxt_r.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RST_B)
		begin
			r_ff <= '0;
			r_ff.st <= PMC_ST_RESET;
			r_ff.rce <= PMC_RCE_RST;
			r_ff.rcs <= PMC_RCS_RST;
			r_ff.sus <= PMC_SUS_RST;
		end
		else
			r_ff <= nxt_r;
	end

	assign PRDATA = r_ff.rdata;
	assign PREADY = r_ff.ready;
	assign PSLVERR = r_ff.err;
	assign SUSPEND_VARIANT = r_ff.sus;
	assign READY = r_ff.rdy;
	assign IRQ = r_ff.irq;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_status_cleared: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		done_p && r_ff.rcs && ~|r_ff.fs2 |=> r_ff.flags == '0)
		else $error("flags not cleared on resume");
	a_cause_hi_cleared: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		done_p && r_ff.rcs && !r_ff.cs2[PMC_BIT_CAUSE_HI] |=>
		!r_ff.cause[PMC_BIT_CAUSE_HI])
		else $error("cause high bit not cleared");
	a_status_kept: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		done_p && !r_ff.rcs && !wr && ~|r_ff.fs2 |=>
		r_ff.flags == $past(r_ff.flags))
		else $error("flags changed with clear-status off");
	a_enables_cleared: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		done_p && r_ff.rce && remote |=> r_ff.clr_en == '0)
		else $error("enables not cleared on remote resume");
	a_host_keeps_en: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		done_p && !remote && !wr |=> $stable(r_ff.clr_en))
		else $error("host resume cleared enables");
	a_keep_en_stable: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		!wr |=> $stable(r_ff.keep_en))
		else $error("excluded enable changed");
	a_rce_write: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		wr && PADDR == PMC_OFS_CTL |=>
		r_ff.rce == $past(PWDATA[PMC_BIT_RCE]))
		else $error("clear-enables write lost");
	a_ready_normal: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		READY |-> r_ff.st == PMC_ST_NORMAL)
		else $error("ready outside normal");
	a_ready_config: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		$rose(READY) |-> $past(r_ff.s2[2]))
		else $error("ready before configuration");
	a_ready_wdog: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		$rose(READY) |-> $past(phy_ok) || $past(r_ff.wdog) >= WDOG_CYCLES)
		else $error("ready before watchdog");
	a_ready_lite: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		lite |=> !READY)
		else $error("ready during lite reset");
	a_variant_write: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		wr && PADDR == PMC_OFS_CTL && !deconf_p |=>
		SUSPEND_VARIANT == $past(PWDATA[PMC_BIT_SUS_LO +: 2]))
		else $error("variant write lost");
	a_deconf_variant: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		deconf_p |=> SUSPEND_VARIANT == PMC_SUS_RST)
		else $error("variant not forced on deconfigure");
	a_cause_w1c: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		wr && PADDR == PMC_OFS_CTL && PWDATA[PMC_BIT_CAUSE_HI] &&
		!r_ff.cs2[PMC_BIT_CAUSE_HI] |=> !r_ff.cause[PMC_BIT_CAUSE_HI])
		else $error("cause bit not cleared by write");
	a_apb_answer: assert property (@(posedge REF_CLK)
		disable iff (!RST_B)
		PSEL && !PENABLE |=> PREADY)
		else $error("apb answer missing");
	c_remote_resume: cover property (@(posedge REF_CLK) done_p && remote);
	c_host_resume: cover property (@(posedge REF_CLK) done_p && !remote);
	c_wdog_ready: cover property (@(posedge REF_CLK) $rose(READY) && !phy_ok);
	c_deconf: cover property (@(posedge REF_CLK) deconf_p);
	c_lite: cover property (@(posedge REF_CLK) lite);
endmodule

// >>> pmc_pkg.sv
// pmc_pkg: constants and types for the power management control block
// assumes a 32-bit apb register bus at byte addresses
package pmc_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] PMC_OFS_CTL = 12'h020;
	localparam logic [11:0] PMC_OFS_WAKE = 12'h028;
	localparam logic [11:0] PMC_OFS_IRQ_STS = 12'h02c;
	localparam logic [11:0] PMC_OFS_IRQ_EN = 12'h030;
	localparam logic [11:0] PMC_OFS_IRQ_CLR = 12'h034;
	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int PMC_BIT_RCS = 9;
	localparam int PMC_BIT_RCE = 8;
	localparam int PMC_BIT_RDY = 7;
	localparam int PMC_BIT_SUS_LO = 5;
	localparam int PMC_BIT_CAUSE_HI = 1;
	localparam int PMC_BIT_CAUSE_LO = 0;
	localparam logic [1:0] PMC_SUS_RST = 2'h2;
	localparam logic PMC_RCE_RST = 1'h1;
	localparam logic PMC_RCS_RST = 1'h0;
	// ----------------------------------------------------------------
	// wake register fields: status flags [3:0], kept enables [8:4],
	// clearable enables [10:9]
	// ----------------------------------------------------------------
	localparam int PMC_N_FLAG = 4;
	localparam int PMC_N_KEEP = 5;
	localparam int PMC_N_CLR = 2;
	localparam int PMC_BIT_KEEP = 4;
	localparam int PMC_BIT_CLR = 9;
	// ----------------------------------------------------------------
	// interrupt status bits
	// ----------------------------------------------------------------
	localparam int PMC_N_IRQ = 3;
	localparam int PMC_IRQ_RESUME = 0;
	localparam int PMC_IRQ_READY = 1;
	localparam int PMC_IRQ_DECONF = 2;
	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	localparam int PMC_CLK_MHZ = 100;
	localparam int PMC_WDOG_US = 100;
	localparam int PMC_WDOG_CYC = PMC_WDOG_US * PMC_CLK_MHZ;
	typedef enum logic [1:0] {
		PMC_ST_RESET,
		PMC_ST_CONFIG,
		PMC_ST_NORMAL
	} pmc_state_t;
endpackage

// >>> pmc_host_model.sv
// pmc_host_model: usb host side, drives resume and deconfigure pins
// assumes the bench calls its tasks; pins change just after REF_CLK
`timescale 1ns/100ps
module pmc_host_model
(
	input wire logic REF_CLK,
	output logic RESUME_DONE,
	output logic RESUME_REMOTE,
	output logic DECONFIG
);
	// ----------------------------------------------------------------
	// pin sequences
	// ----------------------------------------------------------------
	initial
	begin
		RESUME_DONE = 1'b0;
		RESUME_REMOTE = 1'b0;
		DECONFIG = 1'b0;
	end
	// kind is held stable around the done edge
	task automatic resume(input logic remote);
		@(posedge REF_CLK) RESUME_REMOTE <= remote;
		repeat (2) @(posedge REF_CLK);
		RESUME_DONE <= 1'b1;
		repeat (3) @(posedge REF_CLK);
		RESUME_DONE <= 1'b0;
		repeat (6) @(posedge REF_CLK);
	endtask
	task automatic deconfigure();
		@(posedge REF_CLK) DECONFIG <= 1'b1;
		repeat (3) @(posedge REF_CLK);
		DECONFIG <= 1'b0;
		repeat (6) @(posedge REF_CLK);
	endtask
endmodule

// >>> power_mgmt_control_bench.sv
// power_mgmt_control_bench: apb register tests of the power control bank
// assumes pmc_pkg, pmc_power_mgmt_control and pmc_host_model
`timescale 1ns/100ps
module power_mgmt_control_bench;
	import pmc_pkg::*;
	logic clk, rst_b, psel, penable, pwrite, cfg_done;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic pready, pslverr, rd_err, res_done, res_remote, deconf;
	logic [3:0] flag_set;
	logic [1:0] cause_set, variant;
	logic ready, irq, phy_ok, lite;
	int num_errors = 0;
	int checked = 0;
	pmc_power_mgmt_control #(.WDOG_CYCLES(20)) u_pmc_power_mgmt_control (
		.REF_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .RESUME_DONE(res_done),
		.RESUME_REMOTE(res_remote), .CONFIG_DONE(cfg_done),
		.PHY_CLK_OK(phy_ok), .DECONFIG(deconf), .LITE_RESET(lite),
		.FLAG_SET(flag_set), .CAUSE_SET(cause_set),
		.SUSPEND_VARIANT(variant), .READY(ready), .IRQ(irq));
	pmc_host_model u_pmc_host_model (.REF_CLK(clk), .RESUME_DONE(res_done),
		.RESUME_REMOTE(res_remote), .DECONFIG(deconf));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk("prdata", rd_data, exp);
	endtask
	task automatic wrap_up();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		num_errors++;
		wrap_up();
	end
	initial
	begin
		{psel, penable, pwrite, cfg_done, rst_b, phy_ok, lite} = 7'h0;
		{paddr, pwdata, flag_set, cause_set} = 50'h0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rd(PMC_OFS_CTL, 32'h0000_0140);
		chk("variant", variant, 32'h2);
		wr(PMC_OFS_IRQ_EN, 32'h1);
		@(posedge clk) cfg_done <= 1'b1;
		repeat (8) @(posedge clk);
		chk("ready early", ready, 32'h0);
		repeat (30) @(posedge clk);
		chk("ready", ready, 32'h1);
		chk("irq masked", irq, 32'h0);
		for (int v = 0; v < 4; v++)
		begin
			wr(PMC_OFS_CTL, 32'h100 | (v << 5));
			rd(PMC_OFS_CTL, 32'h180 | (v << 5));
			chk("variant", variant, v);
		end
		@(posedge clk) {flag_set, cause_set} <= 6'h3f;
		repeat (3) @(posedge clk);
		{flag_set, cause_set} <= 6'h0;
		wr(PMC_OFS_WAKE, 32'h7f0);
		rd(PMC_OFS_WAKE, 32'h7ff);
		u_pmc_host_model.resume(1'b1);
		rd(PMC_OFS_WAKE, 32'h1ff);
		rd(PMC_OFS_CTL, 32'h1e3);
		chk("irq", irq, 32'h1);
		rd(PMC_OFS_IRQ_STS, 32'h3);
		wr(PMC_OFS_IRQ_CLR, 32'h7);
		rd(PMC_OFS_IRQ_CLR, 32'h0);
		chk("irq cleared", irq, 32'h0);
		wr(PMC_OFS_CTL, 32'h342);
		rd(PMC_OFS_CTL, 32'h3c1);
		@(posedge clk) cause_set <= 2'h2;
		repeat (3) @(posedge clk);
		cause_set <= 2'h0;
		wr(PMC_OFS_WAKE, 32'h7f0);
		u_pmc_host_model.resume(1'b0);
		rd(PMC_OFS_WAKE, 32'h7f0);
		rd(PMC_OFS_CTL, 32'h3c1);
		xfer(1'b0, 12'hff4, 32'h0);
		chk("slverr", rd_err, 32'h1);
		chk("unmapped", rd_data, 32'h0);
		@(posedge clk) lite <= 1'b1;
		repeat (3) @(posedge clk);
		lite <= 1'b0;
		repeat (8) @(posedge clk);
		chk("ready lite", ready, 32'h0);
		repeat (30) @(posedge clk);
		chk("ready lite done", ready, 32'h1);
		wr(PMC_OFS_CTL, 32'h320);
		@(posedge clk);
		chk("variant", variant, 32'h1);
		u_pmc_host_model.deconfigure();
		chk("variant deconf", variant, 32'h2);
		chk("ready deconf", ready, 32'h0);
		rd(PMC_OFS_IRQ_STS, 32'h7);
		@(posedge clk) phy_ok <= 1'b1;
		repeat (6) @(posedge clk);
		chk("ready phy", ready, 32'h1);
		wrap_up();
	end
endmodule
